// *** core/pak_keypad_det.sv ***
// Keypad low-level detector: synchronises port 0 and flags any enabled low pin.
// Assumes raw pin levels and a register-side enable through pak_kp_if.
`timescale 1ns/10ps
`default_nettype none
module pak_keypad_det
    import pak_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    pak_kp_if.det kp
);
    typedef struct packed {
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic hit;
    } pak_det_state_t;

    pak_det_state_t st;
    pak_det_state_t next_st;

    // ==========================================================
    // Two-flop synchroniser, then the low-level detect
    always_comb begin
        next_st = st;
        next_st.sync1 = kp.pins;
        next_st.sync2 = st.sync1;
        // Any enabled pin low, only while the keypad function is on
        next_st.hit = kp.active & (|(~st.sync2 & kp.pin_en));
    end

    // Pins idle high so reset never reports a press
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st <= '{sync1: PINS_IDLE, sync2: PINS_IDLE, hit: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign kp.hit = st.hit;

    a_sync_delay: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !$past(reset_in) && !$past(reset_in, 2) |-> st.sync2 == $past(kp.pins, 2))
        else $error("synchroniser output is not the pin level two cycles back");

    a_hit_cause: assert property (
        @(posedge clk_in) disable iff (reset_in)
        !kp.active |=> !st.hit)
        else $error("keypad hit raised while keypad function off");
endmodule
`default_nettype wire

// *** core/pak_kp_if.sv ***
// Interface between the register block and the keypad pin detector.
// Assumes both ends share one clock.
`timescale 1ns/10ps
`default_nettype none
interface pak_kp_if;
    logic [7:0] pins;
    logic [7:0] pin_en;
    logic active;
    logic hit;
    modport det (input pins, input pin_en, input active, output hit);
    modport ctl (output pins, output pin_en, output active, input hit);
endinterface
`default_nettype wire

// *** core/pak_pkg.sv ***
// Constants and types for the port auxiliary config and keypad interrupt block.
// Assumes a byte-wide register map on a 32-bit classic Wishbone bus.
package pak_pkg;
    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_MODE_A = 8'hA4;
    localparam logic [7:0] ADDR_MODE_B = 8'hA8;
    localparam logic [7:0] ADDR_KP_EN = 8'hAC;
    localparam logic [7:0] ADDR_AUX_ONE = 8'hB0;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'hB4;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'hB8;

    // ==========================================================
    // Field positions in port2_mode_reg_a
    localparam int BIT_P2_SCHMITT = 7;
    localparam int BIT_P1_SCHMITT = 6;
    localparam int BIT_P0_SCHMITT = 5;
    localparam int BIT_CLK_OUT_EN = 4;
    localparam int BIT_TMR1_TGL_EN = 3;
    localparam int BIT_TMR0_TGL_EN = 2;
    localparam int BIT_P2_PIN1 = 1;
    localparam int BIT_P2_PIN0 = 0;

    // Field positions in aux_reg_one
    localparam int BIT_KP_FLAG = 7;
    localparam int BIT_KP_IRQ_EN = 0;

    // Event bits in the interrupt status and mask registers
    localparam int EV_KEYPAD = 0;
    localparam int EV_TMR0 = 1;
    localparam int EV_TMR1 = 2;
    localparam int EV_COUNT = 3;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [EV_COUNT-1:0] RST_EV = 3'h0;
    localparam logic [7:0] PINS_IDLE = 8'hFF;
    localparam logic [23:0] DAT_PAD = 24'h000000;

    // Output type of a port pin, {mode_a bit, mode_b bit}
    typedef enum logic [1:0] {
        OM_QUASI = 2'h0,
        OM_PUSH_PULL = 2'h1,
        OM_INPUT_ONLY = 2'h2,
        OM_OPEN_DRAIN = 2'h3
    } pak_out_mode_t;
endpackage

// *** core/pak_port_aux_top.sv ***
// Port auxiliary configuration and keypad interrupt, with a Wishbone slave.
// Assumes a synchronous CLK_IN domain; timers and pin drivers live outside.
//
// Behaviour
// - Mode-A bits 7,6,5 enable Schmitt inputs on ports 2,1,0.
// - Clock-out enable with RC oscillator drives a clock on port 2 bit 0.
// - Timer 1 toggle enable flips port 0 bit 7 on each overflow.
// - Timer 0 toggle enable flips port 1 bit 2 on each overflow.
// - Mode-A bits 1,0 pair with mode-B bits for port 2 pins 1,0.
// - Pair 00 quasi, 01 push-pull, 10 input only, 11 open drain.
// - Any combination of port 0 pins may be keypad sources.
// - A keypad enable register selects the participating port 0 pins.
// - Enable bit n makes port 0 pin n a keypad source.
// - Flag sets when any enabled pin is low while keypad function active.
// - Keypad interrupt enable must be set before pin enables matter.
// - Keypad request goes out only when flag set and interrupt enabled.
// - Hardware never clears the keypad flag; software writes zero.
// - Enabled keypad interrupt drives the registered KEYPAD_IRQ_REQ_OUT; the wake path from idle and power-down lies outside.
`timescale 1ns/10ps
`default_nettype none
module pak_port_aux_top
    import pak_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [7:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    input wire logic [7:0] PORT0_IN,
    input wire logic RC_OSC_SEL_IN,
    input wire logic TMR0_OVF_IN,
    input wire logic TMR1_OVF_IN,
    output logic [2:0] SCHMITT_EN_OUT,
    output logic XTAL_OUT_PIN_OUT,
    output logic XTAL_OUT_PIN_OE_N_OUT,
    output logic PORT0_BIT7_OUT,
    output logic PORT0_BIT7_OE_N_OUT,
    output logic PORT1_BIT2_OUT,
    output logic PORT1_BIT2_OE_N_OUT,
    output logic [1:0] PORT2_BIT0_MODE_OUT,
    output logic [1:0] PORT2_BIT1_MODE_OUT,
    output logic KEYPAD_IRQ_REQ_OUT,
    output logic IRQ_OUT
);
    typedef struct packed {
        logic [7:0] mode_a;
        logic [7:0] mode_b;
        logic [7:0] kp_en;
        logic kp_flag;
        logic kp_irq_en;
        logic [EV_COUNT-1:0] irq_stat;
        logic [EV_COUNT-1:0] irq_mask;
        logic ack;
        logic [7:0] rdata;
        logic irq;
        logic kp_req;
        logic clk_div;
        logic xtal_oe_n;
        logic tgl_p07;
        logic tgl_p07_oe_n;
        logic tgl_p12;
        logic tgl_p12_oe_n;
        logic [2:0] schmitt;
        logic [1:0] p2_pin0_mode;
        logic [1:0] p2_pin1_mode;
    } pak_state_t;

    pak_state_t st;
    pak_state_t next_st;

    pak_kp_if kp_bus ();

    // ==========================================================
    // Helpers
    // Output type of one port 2 pin from its mode bit pair
    function automatic pak_out_mode_t out_mode(input logic bit_a, input logic bit_b);
        pak_out_mode_t m;
        m = pak_out_mode_t'({bit_a, bit_b});
        return m;
    endfunction

    // ==========================================================
    // Bus decode
    logic req;
    logic wr_lane;
    logic wr_mode_a;
    logic wr_mode_b;
    logic wr_kp_en;
    logic wr_aux_one;
    logic wr_irq_mask;
    logic rd_irq_stat;
    logic kp_flag_rise;
    logic [EV_COUNT-1:0] events;
    logic [7:0] rd_mux;

    // Single-cycle answer; ack drops the cycle after it is given
    assign req = WB_CYC_IN & WB_STB_IN & ~st.ack;
    assign wr_lane = req & WB_WE_IN & WB_SEL_IN[0];
    assign wr_mode_a = wr_lane & (WB_ADR_IN == ADDR_MODE_A);
    assign wr_mode_b = wr_lane & (WB_ADR_IN == ADDR_MODE_B);
    assign wr_kp_en = wr_lane & (WB_ADR_IN == ADDR_KP_EN);
    assign wr_aux_one = wr_lane & (WB_ADR_IN == ADDR_AUX_ONE);
    assign wr_irq_mask = wr_lane & (WB_ADR_IN == ADDR_IRQ_MASK);
    assign rd_irq_stat = req & ~WB_WE_IN & (WB_ADR_IN == ADDR_IRQ_STAT);

    // Read data; unmapped addresses answer zero rather than stall
    always_comb begin
        case (WB_ADR_IN)
            ADDR_MODE_A: rd_mux = st.mode_a;
            ADDR_MODE_B: rd_mux = st.mode_b;
            ADDR_KP_EN: rd_mux = st.kp_en;
            ADDR_AUX_ONE: begin
                rd_mux = RST_BYTE;
                rd_mux[BIT_KP_FLAG] = st.kp_flag;
                rd_mux[BIT_KP_IRQ_EN] = st.kp_irq_en;
            end
            ADDR_IRQ_STAT: rd_mux = {5'h00, st.irq_stat};
            ADDR_IRQ_MASK: rd_mux = {5'h00, st.irq_mask};
            default: rd_mux = RST_BYTE;
        endcase
    end

    // ==========================================================
    // Keypad detector hookup
    assign kp_bus.pins = PORT0_IN;
    assign kp_bus.pin_en = st.kp_en;
    assign kp_bus.active = st.kp_irq_en;

    pak_keypad_det u_det (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .kp(kp_bus.det)
    );

    // Events that feed the sticky status bits
    // Rise taken from the hit itself, so the status path never reads next_st
    assign kp_flag_rise = kp_bus.hit & ~st.kp_flag;
    always_comb begin
        events = RST_EV;
        events[EV_KEYPAD] = kp_flag_rise;
        events[EV_TMR0] = TMR0_OVF_IN & st.mode_a[BIT_TMR0_TGL_EN];
        events[EV_TMR1] = TMR1_OVF_IN & st.mode_a[BIT_TMR1_TGL_EN];
    end

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.ack = req;
        if (req & ~WB_WE_IN) begin
            next_st.rdata = rd_mux;
        end
        if (wr_mode_a) begin
            next_st.mode_a = WB_DAT_IN[7:0];
        end
        if (wr_mode_b) begin
            next_st.mode_b = WB_DAT_IN[7:0];
        end
        if (wr_kp_en) begin
            next_st.kp_en = WB_DAT_IN[7:0];
        end
        if (wr_irq_mask) begin
            next_st.irq_mask = WB_DAT_IN[EV_COUNT-1:0];
        end
        // Software can only clear the flag; writing one leaves it alone
        if (wr_aux_one) begin
            next_st.kp_irq_en = WB_DAT_IN[BIT_KP_IRQ_EN];
            if (!WB_DAT_IN[BIT_KP_FLAG]) begin
                next_st.kp_flag = 1'b0;
            end
        end
        // A press in the clearing cycle still sets the flag
        if (kp_bus.hit) begin
            next_st.kp_flag = 1'b1;
        end
        next_st.kp_req = next_st.kp_flag & next_st.kp_irq_en;

        // Read clears status; a same-cycle event wins
        next_st.irq_stat = (rd_irq_stat ? RST_EV : st.irq_stat) | events;
        next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

        // Pin functions follow the new mode byte two cycles after a write
        next_st.schmitt = st.mode_a[BIT_P2_SCHMITT:BIT_P0_SCHMITT];
        next_st.p2_pin0_mode = out_mode(st.mode_a[BIT_P2_PIN0], st.mode_b[BIT_P2_PIN0]);
        next_st.p2_pin1_mode = out_mode(st.mode_a[BIT_P2_PIN1], st.mode_b[BIT_P2_PIN1]);

        // Clock out at half CLK_IN, only from the RC oscillator source
        if (st.mode_a[BIT_CLK_OUT_EN] & RC_OSC_SEL_IN) begin
            next_st.clk_div = ~st.clk_div;
            next_st.xtal_oe_n = 1'b0;
        end else begin
            next_st.clk_div = 1'b0;
            next_st.xtal_oe_n = 1'b1;
        end

        // Toggle outputs run at half the overflow rate
        next_st.tgl_p07_oe_n = ~st.mode_a[BIT_TMR1_TGL_EN];
        if (st.mode_a[BIT_TMR1_TGL_EN] & TMR1_OVF_IN) begin
            next_st.tgl_p07 = ~st.tgl_p07;
        end
        next_st.tgl_p12_oe_n = ~st.mode_a[BIT_TMR0_TGL_EN];
        if (st.mode_a[BIT_TMR0_TGL_EN] & TMR0_OVF_IN) begin
            next_st.tgl_p12 = ~st.tgl_p12;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            st <= '0;
            st.xtal_oe_n <= 1'b1;
            st.tgl_p07_oe_n <= 1'b1;
            st.tgl_p12_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign WB_DAT_OUT = {DAT_PAD, st.rdata};
    assign WB_ACK_OUT = st.ack;
    assign SCHMITT_EN_OUT = st.schmitt;
    assign XTAL_OUT_PIN_OUT = st.clk_div;
    assign XTAL_OUT_PIN_OE_N_OUT = st.xtal_oe_n;
    assign PORT0_BIT7_OUT = st.tgl_p07;
    assign PORT0_BIT7_OE_N_OUT = st.tgl_p07_oe_n;
    assign PORT1_BIT2_OUT = st.tgl_p12;
    assign PORT1_BIT2_OE_N_OUT = st.tgl_p12_oe_n;
    assign PORT2_BIT0_MODE_OUT = st.p2_pin0_mode;
    assign PORT2_BIT1_MODE_OUT = st.p2_pin1_mode;
    // Registered request; with CLK_IN stopped the wake path must be outside
    assign KEYPAD_IRQ_REQ_OUT = st.kp_req;
    assign IRQ_OUT = st.irq;

    // ==========================================================
    // Checks
    a_schmitt_write: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        wr_mode_a |=> ##1 SCHMITT_EN_OUT == $past(WB_DAT_IN[7:5], 2))
        else $error("Schmitt enables do not follow the mode byte");

    a_clk_out_drive: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        st.mode_a[BIT_CLK_OUT_EN] && RC_OSC_SEL_IN |=> !XTAL_OUT_PIN_OE_N_OUT
            && XTAL_OUT_PIN_OUT != $past(XTAL_OUT_PIN_OUT))
        else $error("clock output not running while enabled");

    a_t1_toggle: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        st.mode_a[BIT_TMR1_TGL_EN] && TMR1_OVF_IN |=> PORT0_BIT7_OUT != $past(PORT0_BIT7_OUT))
        else $error("port 0 bit 7 missed a timer 1 overflow");

    a_t0_toggle: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        !st.mode_a[BIT_TMR0_TGL_EN] |=> $stable(PORT1_BIT2_OUT))
        else $error("port 1 bit 2 toggled while disabled");

    a_p2_mode_pair: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        !$past(RESET_IN) |-> PORT2_BIT1_MODE_OUT ==
            {$past(st.mode_a[BIT_P2_PIN1]), $past(st.mode_b[BIT_P2_PIN1])})
        else $error("port 2 pin 1 output type mismatch");

    a_kp_flag_set: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        kp_bus.hit |=> st.kp_flag && KEYPAD_IRQ_REQ_OUT == st.kp_irq_en)
        else $error("keypad hit did not set the flag");

    a_kp_flag_hold: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        st.kp_flag && !(wr_aux_one && !WB_DAT_IN[BIT_KP_FLAG]) |=> st.kp_flag)
        else $error("keypad flag cleared without a software write");

    a_kp_req_gate: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        KEYPAD_IRQ_REQ_OUT |-> st.kp_flag && st.kp_irq_en)
        else $error("keypad request without flag and enable");

    a_mode_reset: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        $fell(RESET_IN) |-> st.mode_a == RST_BYTE && XTAL_OUT_PIN_OE_N_OUT)
        else $error("mode byte not zero after reset");

    a_ack_single: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        WB_ACK_OUT |=> !WB_ACK_OUT)
        else $error("ack held longer than one cycle");

    // Toggle outputs hold while off and flip on every enabled overflow
    a_t1_hold: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        !st.mode_a[BIT_TMR1_TGL_EN] |=> $stable(PORT0_BIT7_OUT))
        else $error("port 0 bit 7 toggled while disabled");

    a_t0_flip: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        st.mode_a[BIT_TMR0_TGL_EN] && TMR0_OVF_IN |=> PORT1_BIT2_OUT != $past(PORT1_BIT2_OUT))
        else $error("port 1 bit 2 missed a timer 0 overflow");

    a_p2_pin0_pair: assert property (
        @(posedge CLK_IN) disable iff (RESET_IN)
        !$past(RESET_IN) |-> PORT2_BIT0_MODE_OUT ==
            {$past(st.mode_a[BIT_P2_PIN0]), $past(st.mode_b[BIT_P2_PIN0])})
        else $error("port 2 pin 0 output type mismatch");
endmodule
`default_nettype wire

// *** test/pak_keypad_model.sv ***
// Keypad model: switches from port 0 pins to ground.
// Assumes pull-ups on every pin, so a released key reads high.
`timescale 1ns/10ps
`default_nettype none
module pak_keypad_model (
    input wire logic [7:0] press_in,
    output logic [7:0] pins_out
);
    // ==========================================================
    // Pin levels
    // A closed switch pulls its pin low; an open one is pulled high
    assign pins_out = ~press_in;
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the port auxiliary config and keypad interrupt block.
// Assumes the pak_pkg register map and one 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tb
    import pak_pkg::*;
;
    logic clk, rst, cyc, stb, we, ack, rc, ovf0, ovf1, xo, xo_n, b7, b7_n, b2, b2_n, kreq, irq;
    logic [7:0] adr, press, pins;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [2:0] sch;
    logic [1:0] m0, m1;
    int err_total, n_checks, cycles;

    pak_port_aux_top u_dut (.CLK_IN(clk), .RESET_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
        .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .PORT0_IN(pins), .RC_OSC_SEL_IN(rc), .TMR0_OVF_IN(ovf0),
        .TMR1_OVF_IN(ovf1), .SCHMITT_EN_OUT(sch), .XTAL_OUT_PIN_OUT(xo),
        .XTAL_OUT_PIN_OE_N_OUT(xo_n), .PORT0_BIT7_OUT(b7), .PORT0_BIT7_OE_N_OUT(b7_n),
        .PORT1_BIT2_OUT(b2), .PORT1_BIT2_OE_N_OUT(b2_n), .PORT2_BIT0_MODE_OUT(m0),
        .PORT2_BIT1_MODE_OUT(m1), .KEYPAD_IRQ_REQ_OUT(kreq), .IRQ_OUT(irq));
    pak_keypad_model u_keys (.press_in(press), .pins_out(pins));

    // ==========================================================
    // Clock, reset and hang guard
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Classic cycle; ack is sampled at the edge, before the slave updates it
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {DAT_PAD, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("ack wait", 1, 0);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        tick(1);
    endtask
    task automatic pulse(input logic t1, input int n);
        @(posedge clk);
        if (t1) ovf1 <= 1'b1; else ovf0 <= 1'b1;
        repeat (n) @(posedge clk);
        ovf1 <= 1'b0;
        ovf0 <= 1'b0;
        tick(2);
    endtask
    task automatic key(input logic [7:0] p);
        @(posedge clk);
        press <= p;
        tick(6);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        wb(0, ADDR_MODE_A, 0);
        chk("mode_a reset", 0, q);
        chk("outs reset", 32'h7, {sch, xo_n, b7_n, b2_n});
        wb(0, 8'hC0, 8'h55);
        chk("unmapped", 0, q);
    endtask
    task automatic t_schmitt();
        for (int i = 5; i < 8; i++) begin
            wb(1, ADDR_MODE_A, 8'h01 << i);
            tick(2);
            chk("schmitt", 32'h1 << (i - 5), sch);
        end
    endtask
    // Pin 0 and pin 1 always get opposite pairs, so a swap shows
    task automatic t_modes();
        for (int p = 0; p < 4; p++) begin
            wb(1, ADDR_MODE_A, {6'h0, p[1] == 1'b0, p[1]});
            wb(1, ADDR_MODE_B, {6'h0, p[0] == 1'b0, p[0]});
            tick(2);
            chk("pin0 mode", p, m0);
            chk("pin1 mode", 3 - p, m1);
        end
    endtask
    task automatic t_clkout();
        logic x1;
        @(posedge clk);
        rc <= 1'b1;
        wb(1, ADDR_MODE_A, 8'h10);
        tick(2);
        x1 = xo;
        tick(1);
        chk("clk out", !x1, xo);
        chk("clk oe_n", 0, xo_n);
        @(posedge clk);
        rc <= 1'b0;
        tick(3);
        chk("clk out rc off", 0, xo);
    endtask
    task automatic t_timers();
        logic v7, v2;
        wb(1, ADDR_IRQ_MASK, 8'h06);
        wb(1, ADDR_MODE_A, 8'h0C);
        wb(0, ADDR_IRQ_STAT, 0);
        tick(2);
        chk("tgl oe_n", 0, {b7_n, b2_n});
        v7 = b7;
        v2 = b2;
        pulse(1, 1);
        chk("t1 toggle", !v7, b7);
        chk("t1 irq", 1, irq);
        pulse(1, 2);
        chk("t1 twice", !v7, b7);
        pulse(0, 1);
        chk("t0 toggle", !v2, b2);
        chk("t0 other", !v7, b7);
        wb(0, ADDR_IRQ_STAT, 0);
        chk("status", 32'h6, q);
        wb(0, ADDR_IRQ_STAT, 0);
        chk("status cleared", 0, q);
        chk("irq cleared", 0, irq);
        wb(1, ADDR_MODE_A, 8'h00);
        pulse(0, 1);
        chk("t0 off", !v2, b2);
        chk("t0 off oe_n", 1, b2_n);
    endtask
    task automatic t_keypad();
        wb(1, ADDR_KP_EN, 8'hFF);
        wb(1, ADDR_AUX_ONE, 8'h00);
        key(8'h01);
        key(8'h00);
        wb(0, ADDR_AUX_ONE, 0);
        chk("kp off", 0, q);
        wb(1, ADDR_AUX_ONE, 8'h01);
        for (int n = 0; n < 8; n++) begin
            wb(1, ADDR_KP_EN, 8'h01 << n);
            key(8'hFF ^ (8'h01 << n));
            key(8'h00);
            wb(0, ADDR_AUX_ONE, 0);
            chk("kp other pins", 1, q);
            key(8'h01 << n);
            key(8'h00);
            wb(0, ADDR_AUX_ONE, 0);
            chk("kp flag", 32'h81, q);
            chk("kp req", 1, kreq);
            wb(1, ADDR_AUX_ONE, 8'h01);
            tick(1);
            chk("kp cleared", 0, kreq);
        end
        wb(1, ADDR_KP_EN, 8'hFF);
        wb(1, ADDR_IRQ_MASK, 8'h01);
        wb(0, ADDR_IRQ_STAT, 0);
        key(8'hFF);
        key(8'h00);
        chk("kp irq", 1, irq);
        wb(1, ADDR_AUX_ONE, 8'h80);
        tick(1);
        chk("kp req gated", 0, kreq);
        wb(0, ADDR_AUX_ONE, 0);
        chk("kp flag held", 32'h80, q);
        wb(0, ADDR_IRQ_STAT, 0);
        chk("kp status", 1, q);
        tick(1);
        chk("kp irq clear", 0, irq);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        {cyc, stb, we, rc, ovf0, ovf1} = 6'h00;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h00000000;
        press = 8'h00;
        err_total = 0;
        n_checks = 0;
        cycles = 0;
        rst = 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_schmitt();
        t_modes();
        t_clkout();
        t_timers();
        t_keypad();
        tally_and_finish();
    end
endmodule
`default_nettype wire
